// file: common/sor_defs.vh
`ifndef SOR_DEFS_VH
`define SOR_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SOR_ADDR_EXT_CTRL   12'h000
`define SOR_ADDR_ECL0_CTRL  12'h004
`define SOR_ADDR_ECL1_CTRL  12'h008
`define SOR_ADDR_TTL_CTRL   12'h00c
`define SOR_ADDR_INPUT_USE  12'h010
`define SOR_ADDR_STATUS     12'h014

// ----------------------------------------------------------------------
// destination control fields
// ----------------------------------------------------------------------
`define SOR_CTRL_EN_BIT     0
`define SOR_CTRL_SEL_LSB    1
`define SOR_CTRL_SEL_MSB    2
`define SOR_TTL_LINE_LSB    4
`define SOR_TTL_LINE_MSB    6

// source select codes for the front connector
`define SOR_EXT_SRC_TRIG    2'h0
`define SOR_EXT_SRC_REFCLK  2'h1
`define SOR_EXT_SRC_PREARM  2'h2

// source select codes for the ecl lines
`define SOR_ECL_SRC_TRIG    2'h0
`define SOR_ECL_SRC_REFCLK  2'h1
`define SOR_ECL_SRC_EXT     2'h2

// ----------------------------------------------------------------------
// input use fields (reference clock, arm and trigger inputs)
// ----------------------------------------------------------------------
`define SOR_USE_REF_EXT2    0
`define SOR_USE_REF_ECL0    1
`define SOR_USE_REF_ECL1    2
`define SOR_USE_ARM_EXT1    3
`define SOR_USE_ARM_ECL0    4
`define SOR_USE_ARM_ECL1    5
`define SOR_USE_TRG_EXT1    6
`define SOR_USE_TRG_EXT2    7
`define SOR_USE_TRG_ECL0    8
`define SOR_USE_TRG_ECL1    9
`define SOR_USE_ARM_TTL_EN  10
`define SOR_USE_TRG_TTL_EN  11
`define SOR_USE_ARM_TTL_LSB 12
`define SOR_USE_ARM_TTL_MSB 14
`define SOR_USE_TRG_TTL_LSB 15
`define SOR_USE_TRG_TTL_MSB 17
`define SOR_USE_WIDTH       18

// reference kinds
`define SOR_REF_INTERNAL    3'h0
`define SOR_REF_CLK10       3'h1
`define SOR_REF_ECL0        3'h2
`define SOR_REF_ECL1        3'h3
`define SOR_REF_EXT2        3'h4

// reset values
`define SOR_CTRL_RESET      3'h0
`define SOR_TTL_RESET       7'h00
`define SOR_USE_RESET       18'h00000

`endif

// file: src/sor_ref_edge.v
`timescale 1ns/1ps
`default_nettype none

// turns a selected reference clock level into an active-edge pulse
module sor_ref_edge
(
   input  wire       core_clk,
   input  wire       srst,
   input  wire       ref_level,
   input  wire       use_falling,
   output reg        ref_edge
);

   reg ref_prev;

   // ----------------------------------------------------------------------
   // edge detect
   // ----------------------------------------------------------------------
   // registered compare of the previous and current reference level
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         ref_prev <= 1'b0;
         ref_edge <= 1'b0;
      end
      else
      begin
         ref_prev <= ref_level;
         if (use_falling)
            ref_edge <= ref_prev & ~ref_level;
         else
            ref_edge <= ~ref_prev & ref_level;
      end
   end

endmodule

`default_nettype wire

// file: src/sor_router.v
// Summary of operation
// - ECL line fed by trigger pulses once per converter conversion pulse.
// - ECL reference clock rises after external falling or backplane rising edge.
// - ECL line fed from front selection carries that signal inverted.
// - front connector pulses once per conversion pulse when fed by trigger.
// - front reference clock falls after external falling or backplane rising edge.
// - front pre-arm selection idles high, low once pre-arm count reached.
// - TTL ready line low while initiated, high after readings, low next burst.
// - post-arm only: ready returns high after arm and trigger counts met.
// - inputs: reference, arm and trigger lines per allowed connector list.
// - never drive a line currently used as reference, arm or trigger input.
// - each destination has own enable; drives only while enabled.
// - ECL lines 0 and 1 have independent source selects.
// - TTL destination selects one of eight lines 0 to 7.
// - pre-arm reached flag follows pre-arm count after initiation.
`timescale 1ns/1ps
`default_nettype none
`include "sor_defs.vh"

module sor_router
(
   input  wire        core_clk,
   input  wire        srst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // internal synchronization sources
   input  wire        conv_pulse,
   input  wire        sample_reference_clock,
   input  wire [2:0]  ref_kind,
   input  wire        initiated,
   input  wire        readings_done,
   input  wire        post_arm_only,
   input  wire        arm_count_met,
   input  wire        trig_count_met,
   input  wire        pre_arm_count_reached,
   // front connector, active low ttl
   output reg         ext1_out,
   output reg         ext1_oe,
   // ecl backplane lines, active high
   output reg  [1:0]  ecl_out,
   output reg  [1:0]  ecl_oe,
   // ttl backplane lines, open collector, active low
   output reg  [7:0]  ttl_out,
   output reg  [7:0]  ttl_oe
);

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   reg [2:0]  ext_ctrl;
   reg [2:0]  ecl0_ctrl;
   reg [2:0]  ecl1_ctrl;
   reg [6:0]  ttl_ctrl;
   reg [`SOR_USE_WIDTH-1:0] input_use;

   wire       wr_en;
   wire       ref_falling;
   wire       ref_edge;
   reg        ext_level;
   reg        ready_level;
   reg        in_burst;
   reg [1:0]  ecl_level;
   reg [1:0]  ecl_blocked;
   reg        ext_blocked;
   reg [7:0]  ttl_blocked;
   reg [31:0] next_prdata;
   reg        addr_hit;
   integer    i;
   // destination drive permissions
   reg        ext_drive;
   reg [1:0]  ecl_drive;
   reg [7:0]  ttl_drive;
   integer    j;
   integer    k;

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;

   // register writes take effect at the access edge
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         ext_ctrl  <= `SOR_CTRL_RESET;
         ecl0_ctrl <= `SOR_CTRL_RESET;
         ecl1_ctrl <= `SOR_CTRL_RESET;
         ttl_ctrl  <= `SOR_TTL_RESET;
         input_use <= `SOR_USE_RESET;
      end
      else if (wr_en)
      begin
         case (paddr)
            `SOR_ADDR_EXT_CTRL:  ext_ctrl  <= pwdata[2:0];
            `SOR_ADDR_ECL0_CTRL: ecl0_ctrl <= pwdata[2:0];
            `SOR_ADDR_ECL1_CTRL: ecl1_ctrl <= pwdata[2:0];
            `SOR_ADDR_TTL_CTRL:  ttl_ctrl  <= pwdata[6:0];
            `SOR_ADDR_INPUT_USE: input_use <= pwdata[`SOR_USE_WIDTH-1:0];
            default:             ;
         endcase
      end
   end

   // read mux, unmapped addresses read as zero
   always @*
   begin
      next_prdata = 32'h00000000;
      addr_hit    = 1'b1;
      case (paddr)
         `SOR_ADDR_EXT_CTRL:  next_prdata = {29'h0, ext_ctrl};
         `SOR_ADDR_ECL0_CTRL: next_prdata = {29'h0, ecl0_ctrl};
         `SOR_ADDR_ECL1_CTRL: next_prdata = {29'h0, ecl1_ctrl};
         `SOR_ADDR_TTL_CTRL:  next_prdata = {25'h0, ttl_ctrl};
         `SOR_ADDR_INPUT_USE: next_prdata = {14'h0, input_use};
         `SOR_ADDR_STATUS:    next_prdata = {27'h0, ready_level, ext_level,
                                             pre_arm_count_reached, ecl_level};
         default:             addr_hit    = 1'b0;
      endcase
   end

   // read data registered, valid from the access phase onward
   always @(posedge core_clk)
   begin
      if (srst)
         prdata <= 32'h00000000;
      else if (psel & ~penable & ~pwrite)
         prdata <= addr_hit ? next_prdata : 32'h00000000;
   end

   // ----------------------------------------------------------------------
   // reference clock edge
   // ----------------------------------------------------------------------
   // external port reference acts on its falling edge, backplane ones on rising
   assign ref_falling = (ref_kind == `SOR_REF_EXT2);

   sor_ref_edge u_ref_edge
   (
      .core_clk    (core_clk),
      .srst        (srst),
      .ref_level   (sample_reference_clock),
      .use_falling (ref_falling),
      .ref_edge    (ref_edge)
   );

   // ----------------------------------------------------------------------
   // ready level
   // ----------------------------------------------------------------------
   // low during a burst, high once readings complete
   always @(posedge core_clk)
   begin
      if (srst)
         in_burst <= 1'b0;
      else if (initiated & ~in_burst)
         in_burst <= 1'b1;
      else if (in_burst & (post_arm_only ? (arm_count_met & trig_count_met)
                                         : readings_done))
         in_burst <= 1'b0;
   end

   // ----------------------------------------------------------------------
   // blocking of input-used lines
   // ----------------------------------------------------------------------
   // a line claimed as an input, or feeding the reference, is never driven
   always @*
   begin
      ext_blocked    = input_use[`SOR_USE_ARM_EXT1] | input_use[`SOR_USE_TRG_EXT1];
      ecl_blocked[0] = input_use[`SOR_USE_REF_ECL0] | input_use[`SOR_USE_ARM_ECL0]
                       | input_use[`SOR_USE_TRG_ECL0]
                       | (ref_kind == `SOR_REF_ECL0);
      ecl_blocked[1] = input_use[`SOR_USE_REF_ECL1] | input_use[`SOR_USE_ARM_ECL1]
                       | input_use[`SOR_USE_TRG_ECL1]
                       | (ref_kind == `SOR_REF_ECL1);
      for (i = 0; i < 8; i = i + 1)
         ttl_blocked[i] =
            (input_use[`SOR_USE_ARM_TTL_EN] &
             (input_use[`SOR_USE_ARM_TTL_MSB:`SOR_USE_ARM_TTL_LSB] == i[2:0])) |
            (input_use[`SOR_USE_TRG_TTL_EN] &
             (input_use[`SOR_USE_TRG_TTL_MSB:`SOR_USE_TRG_TTL_LSB] == i[2:0]));
   end

   // ----------------------------------------------------------------------
   // drive permission per destination
   // ----------------------------------------------------------------------
   // a destination drives only while enabled and not claimed as an input
   always @*
   begin
      ext_drive    = ext_ctrl[`SOR_CTRL_EN_BIT] & ~ext_blocked;
      ecl_drive[0] = ecl0_ctrl[`SOR_CTRL_EN_BIT] & ~ecl_blocked[0];
      ecl_drive[1] = ecl1_ctrl[`SOR_CTRL_EN_BIT] & ~ecl_blocked[1];
      for (k = 0; k < 8; k = k + 1)
         ttl_drive[k] = ttl_ctrl[`SOR_CTRL_EN_BIT] & ~ttl_blocked[k] &
                        (ttl_ctrl[`SOR_TTL_LINE_MSB:`SOR_TTL_LINE_LSB] == k[2:0]);
   end

   // ----------------------------------------------------------------------
   // source selection
   // ----------------------------------------------------------------------
   // front connector levels, active low: pulse low for trigger and clock
   always @*
   begin
      case (ext_ctrl[`SOR_CTRL_SEL_MSB:`SOR_CTRL_SEL_LSB])
         `SOR_EXT_SRC_TRIG:   ext_level = ~conv_pulse;
         `SOR_EXT_SRC_REFCLK: ext_level = ~ref_edge;
         `SOR_EXT_SRC_PREARM: ext_level = ~pre_arm_count_reached;
         default:             ext_level = 1'b1;
      endcase
      ready_level = ~in_burst;
   end

   // ecl levels, each with its own selector
   always @*
   begin
      case (ecl0_ctrl[`SOR_CTRL_SEL_MSB:`SOR_CTRL_SEL_LSB])
         `SOR_ECL_SRC_TRIG:   ecl_level[0] = conv_pulse;
         `SOR_ECL_SRC_REFCLK: ecl_level[0] = ref_edge;
         `SOR_ECL_SRC_EXT:    ecl_level[0] = ~ext_level;
         default:             ecl_level[0] = 1'b0;
      endcase
      case (ecl1_ctrl[`SOR_CTRL_SEL_MSB:`SOR_CTRL_SEL_LSB])
         `SOR_ECL_SRC_TRIG:   ecl_level[1] = conv_pulse;
         `SOR_ECL_SRC_REFCLK: ecl_level[1] = ref_edge;
         `SOR_ECL_SRC_EXT:    ecl_level[1] = ~ext_level;
         default:             ecl_level[1] = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------------
   // released destinations sit at their idle level with enable low
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         ext1_out <= 1'b1;
         ext1_oe  <= 1'b0;
         ecl_out  <= 2'h0;
         ecl_oe   <= 2'h0;
         ttl_out  <= 8'hff;
         ttl_oe   <= 8'h00;
      end
      else
      begin
         if (ext_drive)
         begin
            ext1_out <= ext_level;
            ext1_oe  <= 1'b1;
         end
         else
         begin
            ext1_out <= 1'b1;
            ext1_oe  <= 1'b0;
         end
         // each ecl line: selected level while allowed, low and released otherwise
         if (ecl_drive[0])
         begin
            ecl_out[0] <= ecl_level[0];
            ecl_oe[0]  <= 1'b1;
         end
         else
         begin
            ecl_out[0] <= 1'b0;
            ecl_oe[0]  <= 1'b0;
         end
         if (ecl_drive[1])
         begin
            ecl_out[1] <= ecl_level[1];
            ecl_oe[1]  <= 1'b1;
         end
         else
         begin
            ecl_out[1] <= 1'b0;
            ecl_oe[1]  <= 1'b0;
         end
         // only the selected ttl line carries the ready level
         for (j = 0; j < 8; j = j + 1)
         begin
            if (ttl_drive[j])
            begin
               ttl_out[j] <= ready_level;
               ttl_oe[j]  <= 1'b1;
            end
            else
            begin
               ttl_out[j] <= 1'b1;
               ttl_oe[j]  <= 1'b0;
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: sim/sor_router_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sor_router_chk
(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        conv_pulse,
   input wire logic        sample_reference_clock,
   input wire logic [2:0]  ref_kind,
   input wire logic        pre_arm_count_reached,
   input wire logic        ext1_out,
   input wire logic        ext1_oe,
   input wire logic [1:0]  ecl_out,
   input wire logic [1:0]  ecl_oe,
   input wire logic [7:0]  ttl_out,
   input wire logic [7:0]  ttl_oe
);
   // ----------
   // shadow of the destination controls
   // ----------
   logic [31:0] c_ext, c_e0, c_e1, c_ttl, c_use;
   wire logic   e0_free = !(c_use[1] | c_use[4] | c_use[8] | (ref_kind == 3'h2));
   wire logic   e1_free = !(c_use[2] | c_use[5] | c_use[9] | (ref_kind == 3'h3));
   wire logic   x_free = !(c_use[3] | c_use[6]);

   // follow every completed apb write
   always_ff @(posedge core_clk)
      if (srst)
         {c_ext, c_e0, c_e1, c_ttl, c_use} <= '0;
      else if (psel && penable && pwrite && pready)
         case (paddr)
            12'h000: c_ext <= pwdata;
            12'h004: c_e0 <= pwdata;
            12'h008: c_e1 <= pwdata;
            12'h00c: c_ttl <= pwdata;
            12'h010: c_use <= pwdata;
            default: ;
         endcase

   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   // ecl1 copies the front level, inverted, once both have settled
   sequence front_steady_s;
      c_e1[2:0] == 3'h5 && e1_free && ext1_oe && $stable(ext1_out);
   endsequence

   ecl_trig_a: assert property (c_e0[2:0] == 3'h1 && e0_free
      |=> ecl_oe[0] && ecl_out[0] == $past(conv_pulse)) else $error("ecl0 trigger wrong");
   ecl_ref_a: assert property (c_e1[2:0] == 3'h3 && e1_free && ref_kind == 3'h1
      && $rose(sample_reference_clock) |-> ##[1:3] ecl_out[1]) else $error("ecl1 ref edge");
   ecl_inv_a: assert property (front_steady_s [*3]
      |-> ecl_oe[1] && ecl_out[1] == !ext1_out) else $error("ecl1 not inverted");
   ext_trig_a: assert property (c_ext[2:0] == 3'h1 && x_free
      |=> ext1_oe && ext1_out == !$past(conv_pulse)) else $error("front trigger wrong");
   ext_ref_a: assert property (c_ext[2:0] == 3'h3 && x_free && ref_kind == 3'h4
      && $fell(sample_reference_clock) |-> ##[1:3] !ext1_out) else $error("front ref edge");
   ext_prearm_a: assert property (c_ext[2:0] == 3'h5 && x_free
      |=> ext1_out == !$past(pre_arm_count_reached)) else $error("front pre-arm level");
   ecl_block_a: assert property (!e0_free |=> !ecl_oe[0]) else $error("ecl0 driven");
   ext_block_a: assert property (!x_free |=> !ext1_oe && ext1_out) else $error("front driven");
   ecl_off_a: assert property (!c_e1[0] |=> !ecl_oe[1] && !ecl_out[1]) else $error("ecl1 on");
   ttl_off_a: assert property (!c_ttl[0]
      |=> ttl_oe == 8'h00 && ttl_out == 8'hff) else $error("ttl not idle");
   ttl_line_a: assert property (c_ttl[0]
      |=> (ttl_oe & ~(8'h01 << $past(c_ttl[6:4]))) == 8'h00) else $error("wrong ttl line");
endmodule

bind sor_router sor_router_chk u_chk
(
   .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .paddr(paddr), .pwdata(pwdata), .conv_pulse(conv_pulse),
   .sample_reference_clock(sample_reference_clock), .ref_kind(ref_kind),
   .pre_arm_count_reached(pre_arm_count_reached), .ext1_out(ext1_out), .ext1_oe(ext1_oe),
   .ecl_out(ecl_out), .ecl_oe(ecl_oe), .ttl_out(ttl_out), .ttl_oe(ttl_oe)
);
`default_nettype wire

// file: sim/sor_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// other instruments sharing the backplane trigger lines
module sor_far_end
(
   input  wire logic [1:0] ecl_out,
   input  wire logic [1:0] ecl_oe,
   input  wire logic [1:0] ecl_other,
   input  wire logic [7:0] ttl_out,
   input  wire logic [7:0] ttl_oe,
   output wire logic [1:0] ecl_wire,
   output wire logic [7:0] ttl_wire
);
   // another instrument drives an ecl line whenever ours lets go
   assign ecl_wire = (ecl_oe & ecl_out) | (~ecl_oe & ecl_other);
   // open collector lines with a pull-up
   assign ttl_wire = ~(ttl_oe & ~ttl_out);
endmodule
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ----------
   // stimulus, observation and checking
   // ----------
   logic        core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, conv_pulse = 0;
   logic        sample_reference_clock = 0, initiated = 0, readings_done = 0, post_arm_only = 0;
   logic        arm_count_met = 0, trig_count_met = 0, pre_arm_count_reached = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [2:0]  ref_kind = 0;
   logic [1:0]  ecl_out, ecl_oe, ecl_wire, ecl_other = 2'b11;
   logic [7:0]  ttl_out, ttl_oe, ttl_wire;
   logic        pready, pslverr, ext1_out, ext1_oe;
   int          mismatches = 0, comparisons = 0, e0_hi, e1_hi, x_lo, i;
   int          bits [5] = '{1, 4, 8, 3, 6};
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
   $display("Error at %0t: got %0h expected %0h", $time, a, e); end end

   always #50 core_clk = !core_clk;

   sor_router u_dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_pulse(conv_pulse), .sample_reference_clock(sample_reference_clock),
      .ref_kind(ref_kind), .initiated(initiated), .readings_done(readings_done),
      .post_arm_only(post_arm_only), .arm_count_met(arm_count_met),
      .trig_count_met(trig_count_met), .pre_arm_count_reached(pre_arm_count_reached),
      .ext1_out(ext1_out), .ext1_oe(ext1_oe), .ecl_out(ecl_out), .ecl_oe(ecl_oe),
      .ttl_out(ttl_out), .ttl_oe(ttl_oe));
   sor_far_end u_far (.ecl_out(ecl_out), .ecl_oe(ecl_oe), .ecl_other(ecl_other),
      .ttl_out(ttl_out), .ttl_oe(ttl_oe), .ecl_wire(ecl_wire), .ttl_wire(ttl_wire));

   // count output pulses mid-cycle, where they have settled
   always @(negedge core_clk)
   begin
      e0_hi += ecl_out[0];
      e1_hi += ecl_out[1];
      x_lo += !ext1_out;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic clr;
      e0_hi = 0;
      e1_hi = 0;
      x_lo = 0;
   endtask

   // one apb transfer; read data lands in rd
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic conv(input int n);
      repeat (n)
      begin
         conv_pulse <= 1'b1;
         @(posedge core_clk);
         conv_pulse <= 1'b0;
         cyc(3);
      end
   endtask

   task automatic refw(input int n);
      repeat (n)
      begin
         sample_reference_clock <= !sample_reference_clock;
         cyc(3);
      end
   endtask

   task automatic strobe(input bit start);
      initiated <= start;
      readings_done <= !start;
      @(posedge core_clk);
      initiated <= 1'b0;
      readings_done <= 1'b0;
      cyc(2);
   endtask

   task automatic final_report;
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // watchdog against a hung transfer
   initial
   begin
      cyc(20000);
      mismatches++;
      final_report;
   end

   // main sequence
   initial
   begin
      cyc(3);
      srst <= 1'b0;
      for (i = 0; i < 6; i++)
      begin
         apb(1'b0, (i == 5) ? 12'h020 : 12'(i * 4), 32'h0);
         `CHK(rd, 32'h0)
      end
      `CHK({ext1_oe, ecl_oe, ttl_oe, ttl_out, pready, pslverr}, 21'h003fe)
      apb(1'b1, 12'h004, 32'h1);
      apb(1'b1, 12'h008, 32'h3);
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rd, 32'h3)
      ref_kind <= 3'h1;
      cyc(4);
      clr;
      conv(3);
      `CHK({e0_hi, e1_hi}, {32'd3, 32'd0})
      clr;
      refw(3);
      `CHK({e0_hi, e1_hi}, {32'd0, 32'd2})
      ref_kind <= 3'h4;
      cyc(4);
      clr;
      refw(3);
      `CHK(e1_hi, 2)
      apb(1'b1, 12'h000, 32'h1);
      clr;
      conv(2);
      `CHK({x_lo, e0_hi}, {32'd2, 32'd2})
      apb(1'b1, 12'h000, 32'h3);
      cyc(4);
      clr;
      refw(3);
      `CHK(x_lo, 1)
      apb(1'b1, 12'h000, 32'h5);
      apb(1'b1, 12'h008, 32'h5);
      cyc(3);
      `CHK({ext1_out, ecl_out[1]}, 2'b10)
      pre_arm_count_reached <= 1'b1;
      cyc(3);
      `CHK({ext1_out, ecl_out[1]}, 2'b01)
      apb(1'b0, 12'h014, 32'h0);
      `CHK(rd[2], 1'b1)
      for (i = 0; i < 5; i++)
      begin
         apb(1'b1, 12'h010, 32'h1 << bits[i]);
         cyc(2);
         `CHK({ecl_oe[0], ext1_oe, ecl_wire[0]}, (i < 3) ? 3'b011 : 3'b100)
      end
      ref_kind <= 3'h2;
      cyc(2);
      `CHK(ecl_oe[0], 1'b0)
      ref_kind <= 3'h4;
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b1, 12'h008, 32'h0);
      cyc(2);
      `CHK(ecl_oe, 2'b01)
      for (i = 0; i < 8; i++)
      begin
         apb(1'b1, 12'h00c, 32'h1 | (i << 4));
         strobe(1'b1);
         `CHK(ttl_wire, ~(8'h01 << i))
         strobe(1'b0);
         `CHK(ttl_wire, 8'hff)
      end
      post_arm_only <= 1'b1;
      arm_count_met <= 1'b1;
      strobe(1'b1);
      strobe(1'b0);
      `CHK(ttl_wire[7], 1'b0)
      trig_count_met <= 1'b1;
      cyc(3);
      `CHK(ttl_wire[7], 1'b1)
      apb(1'b1, 12'h00c, 32'h0);
      cyc(2);
      `CHK(ttl_oe, 8'h00)
      final_report;
   end
endmodule
`default_nettype wire
